/* hdl/tbc_time_base.sv */
`timescale 1ns/1ps
// Function
// - slow chain divides slow clock into binary taps 32 kHz down to 1 Hz.
// - fast section produces divide-by-1 through divide-by-32 outputs.
// - four periodic interrupts from 128, 32, 16 and 2 Hz taps.
// - tap register reads eight taps, 1 Hz bit 7 down to 128 Hz bit 0.
// - any write to tap register clears the eight taps, data ignored.
// - falling edge coinciding with tap register write still requests interrupt.
// - after reset the slow chain counts from zero on slow clock falling edge.
// - each interrupt tap requests on its own falling edge.
// - every slow tap is available as a peripheral clock.
// - fast section is 4-bit counter dividing fast clock by 1 to 16.
// - divide field bits 3-0 select divisor sixteen minus field.
// - divider register resets to zero, giving one sixteenth.
// - selected divided clock feeds timers and the PWM function.
// - tap register reads all zeros after reset.
// - pin 0 outputs fast clock when select high is 1 and low is 0.
// - while pin 0 outputs fast clock its data bit has no effect.
module tbc_time_base
  import tbc_pkg::*;
#(
  parameter int DIV_W = 4
) (
  // clock and reset
  input  wire logic                         clock,
  input  wire logic                         arst_n,
  // slow clock from the pin, sampled here
  input  wire logic                         slow_system_clock,
  // register port
  input  wire tbc_pkg::tbc_bus_req_t        bus_req,
  output logic [7:0]                        bus_rdata,
  // taps and requests
  output logic [tbc_pkg::TBC_CHAIN_W-1:0]   slow_taps,
  output tbc_pkg::tbc_irq_t                 irq,
  // fast divided outputs
  output logic [5:0]                        fast_div_taps,
  output logic                              fast_divided_clock,
  output logic                              fast_div_tick,
  // port b pin 0
  output logic                              port_b_pin0_o,
  output logic                              port_b_pin0_oe_n
);
  import tbc_pkg::*;

  logic [TBC_SYNC_W-1:0]    sync_reg;
  logic                     slow_level_reg;
  logic                     slow_fall;
  logic [TBC_CHAIN_W-1:0]   chain_reg;
  logic [TBC_CHAIN_W-1:0]   chain_next;
  logic [7:0]               tap_view;
  logic [7:0]               tap_prev_reg;
  logic [7:0]               tap_fall;
  logic                     tap_wr;
  logic [7:0]               high_div_reg;
  logic [7:0]               pb_data_reg;
  logic [7:0]               pb_dir_reg;
  logic [7:0]               pb_cfg_lo_reg;
  logic [7:0]               pb_cfg_hi_reg;
  logic [7:0]               pb_fsel_lo_reg;
  logic [7:0]               pb_fsel_hi_reg;
  logic [4:0]               fast_cnt_reg;
  logic                     clk_out_sel;
  logic                     fast_clk_raw_reg;

  // ---------------------------------------------------------------
  // slow clock sampling
  // ---------------------------------------------------------------
  // the slow clock is far slower than the bus clock, so it is
  // treated as a sampled pin rather than a second clock domain
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= {sync_reg[TBC_SYNC_W-2:0], slow_system_clock};
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      slow_level_reg <= 1'b0;
    end else if (sync_reg[1] == sync_reg[2]) begin
      slow_level_reg <= sync_reg[2];
    end
  end

  assign slow_fall = slow_level_reg && (sync_reg[1] == sync_reg[2])
                     && !sync_reg[2];

  // ---------------------------------------------------------------
  // slow chain
  // ---------------------------------------------------------------
  assign tap_wr = bus_req.wr && (bus_req.addr == TBC_ADDR_LOW_TAP);

  always_comb begin
    chain_next = chain_reg;
    if (slow_fall) begin
      chain_next = chain_reg + 1'b1;
    end
    if (tap_wr) begin
      // only the eight upper taps clear; the fast taps run on
      chain_next[TBC_CHAIN_W-1:TBC_TAP_LSB] = '0;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      chain_reg <= '0;
    end else begin
      chain_reg <= chain_next;
    end
  end

  // tap k of the chain toggles at 2^15 / 2^(k+1) Hz: bit 0 = 16 kHz
  // square wave, i.e. the 32 kHz tap is the sampled clock itself
  assign slow_taps = chain_reg;
  assign tap_view  = chain_reg[TBC_CHAIN_W-1:TBC_TAP_LSB];

  // ---------------------------------------------------------------
  // interrupt requests
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tap_prev_reg <= '0;
    end else begin
      tap_prev_reg <= tap_view;
    end
  end

  // a write forcing a high tap to zero is a falling edge too,
  // so the request is not lost when write and edge coincide
  assign tap_fall = tap_prev_reg & ~tap_view;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      irq <= '0;
    end else begin
      irq.req[0] <= tap_fall[TBC_IRQ_128];
      irq.req[1] <= tap_fall[TBC_IRQ_32];
      irq.req[2] <= tap_fall[TBC_IRQ_16];
      irq.req[3] <= tap_fall[TBC_IRQ_2];
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      high_div_reg <= TBC_RST_HIGH_DIV;
    end else if (bus_req.wr && bus_req.addr == TBC_ADDR_HIGH_DIV) begin
      high_div_reg <= {4'h0, bus_req.wdata[TBC_DIV_MSB:0]};
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pb_data_reg    <= TBC_RST_PB_DATA;
      pb_dir_reg     <= TBC_RST_PB_DIR;
      pb_cfg_lo_reg  <= TBC_RST_PB_CFG;
      pb_cfg_hi_reg  <= TBC_RST_PB_CFG;
      pb_fsel_lo_reg <= TBC_RST_PB_FSEL;
      pb_fsel_hi_reg <= TBC_RST_PB_FSEL;
    end else if (bus_req.wr) begin
      unique case (bus_req.addr)
        TBC_ADDR_PB_DATA:    pb_data_reg    <= bus_req.wdata;
        TBC_ADDR_PB_DIR:     pb_dir_reg     <= bus_req.wdata;
        TBC_ADDR_PB_CFG_LO:  pb_cfg_lo_reg  <= bus_req.wdata;
        TBC_ADDR_PB_CFG_HI:  pb_cfg_hi_reg  <= bus_req.wdata;
        TBC_ADDR_PB_FSEL_LO: pb_fsel_lo_reg <= bus_req.wdata;
        TBC_ADDR_PB_FSEL_HI: pb_fsel_hi_reg <= bus_req.wdata;
        default: ;
      endcase
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      bus_rdata <= TBC_RST_LOW_TAP;
    end else if (!bus_req.rd) begin
      bus_rdata <= '0;
    end else begin
      unique case (bus_req.addr)
        TBC_ADDR_LOW_TAP:    bus_rdata <= tap_view;
        TBC_ADDR_HIGH_DIV:   bus_rdata <= high_div_reg;
        TBC_ADDR_PB_DATA:    bus_rdata <= pb_data_reg;
        TBC_ADDR_PB_DIR:     bus_rdata <= pb_dir_reg;
        TBC_ADDR_PB_CFG_LO:  bus_rdata <= pb_cfg_lo_reg;
        TBC_ADDR_PB_CFG_HI:  bus_rdata <= pb_cfg_hi_reg;
        TBC_ADDR_PB_FSEL_LO: bus_rdata <= pb_fsel_lo_reg;
        TBC_ADDR_PB_FSEL_HI: bus_rdata <= pb_fsel_hi_reg;
        default:             bus_rdata <= '0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // fast section
  // ---------------------------------------------------------------
  tbc_fast_div #(
    .DIV_W (DIV_W)
  ) u_fast_div (
    .clock              (clock),
    .arst_n             (arst_n),
    .div_field          (high_div_reg[DIV_W-1:0]),
    .tick               (fast_div_tick),
    .fast_divided_clock (fast_divided_clock)
  );

  // fixed binary taps: bit 0 is the clock itself, bits 1..5 divide by
  // 2..32; bit 0 is a pass enable since a flop cannot toggle at clock
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      fast_cnt_reg <= '0;
    end else begin
      fast_cnt_reg <= fast_cnt_reg + 1'b1;
    end
  end

  assign fast_div_taps = {fast_cnt_reg, 1'b1};

  // ---------------------------------------------------------------
  // port b pin 0 clock output
  // ---------------------------------------------------------------
  assign clk_out_sel = pb_fsel_hi_reg[TBC_PIN0]
                       && !pb_fsel_lo_reg[TBC_PIN0];

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      fast_clk_raw_reg <= 1'b0;
    end else begin
      fast_clk_raw_reg <= ~fast_clk_raw_reg;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      port_b_pin0_o    <= 1'b0;
      port_b_pin0_oe_n <= 1'b1;
    end else begin
      // drive enable follows the dir bit alone; the cfg registers do not reach the pin
      port_b_pin0_oe_n <= pb_dir_reg[TBC_PIN0];
      port_b_pin0_o    <= clk_out_sel ? fast_clk_raw_reg
                                      : pb_data_reg[TBC_PIN0];
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_wr_clears;
    @(posedge clock) disable iff (!arst_n)
      tap_wr |=> tap_view == 8'h00;
  endproperty
  a_wr_clears: assert property (p_wr_clears)
    else $error("tap write did not clear taps");

  property p_irq_128;
    @(posedge clock) disable iff (!arst_n)
      $fell(tap_view[TBC_IRQ_128]) |=> irq.req[0];
  endproperty
  a_irq_128: assert property (p_irq_128)
    else $error("128 Hz request missing");

  property p_irq_2_cause;
    @(posedge clock) disable iff (!arst_n)
      irq.req[3] |-> $past(tap_prev_reg[TBC_IRQ_2], 1)
                     && !$past(tap_view[TBC_IRQ_2], 1);
  endproperty
  a_irq_2_cause: assert property (p_irq_2_cause)
    else $error("2 Hz request without falling edge");

  property p_wr_edge;
    @(posedge clock) disable iff (!arst_n)
      (tap_wr && tap_view[TBC_IRQ_16]) |-> ##2 irq.req[2];
  endproperty
  a_wr_edge: assert property (p_wr_edge)
    else $error("request lost on tap write");

  property p_count;
    @(posedge clock) disable iff (!arst_n)
      (slow_fall && !tap_wr) |=> chain_reg == $past(chain_reg) + 1'b1;
  endproperty
  a_count: assert property (p_count)
    else $error("chain did not advance on slow falling edge");

  property p_hold;
    @(posedge clock) disable iff (!arst_n)
      (!slow_fall && !tap_wr) |=> $stable(chain_reg);
  endproperty
  a_hold: assert property (p_hold)
    else $error("chain moved without slow edge");

  property p_div_upper;
    @(posedge clock) disable iff (!arst_n)
      (bus_req.wr && bus_req.addr == TBC_ADDR_HIGH_DIV)
        |=> high_div_reg == {4'h0, $past(bus_req.wdata[TBC_DIV_MSB:0])};
  endproperty
  a_div_upper: assert property (p_div_upper)
    else $error("divider upper bits not zero");

  property p_pin_data;
    @(posedge clock) disable iff (!arst_n)
      clk_out_sel ##1 clk_out_sel |-> port_b_pin0_o == $past(fast_clk_raw_reg);
  endproperty
  a_pin_data: assert property (p_pin_data)
    else $error("pin follows data bit in clock mode");

  property p_tap_read;
    @(posedge clock) disable iff (!arst_n)
      (bus_req.rd && bus_req.addr == TBC_ADDR_LOW_TAP)
        |=> bus_rdata == $past(tap_view);
  endproperty
  a_tap_read: assert property (p_tap_read)
    else $error("tap readback wrong");

endmodule : tbc_time_base

/* common/tbc_pkg.sv */
package tbc_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [15:0] TBC_ADDR_LOW_TAP    = 16'hf00a;
  localparam logic [15:0] TBC_ADDR_HIGH_DIV   = 16'hf00b;
  localparam logic [15:0] TBC_ADDR_PB_DATA    = 16'hf258;
  localparam logic [15:0] TBC_ADDR_PB_DIR     = 16'hf259;
  localparam logic [15:0] TBC_ADDR_PB_CFG_LO  = 16'hf25a;
  localparam logic [15:0] TBC_ADDR_PB_CFG_HI  = 16'hf25b;
  localparam logic [15:0] TBC_ADDR_PB_FSEL_LO = 16'hf25c;
  localparam logic [15:0] TBC_ADDR_PB_FSEL_HI = 16'hf25d;

  // ---------------------------------------------------------------
  // reset values and fields
  // ---------------------------------------------------------------
  localparam logic [7:0] TBC_RST_LOW_TAP  = 8'h00;
  localparam logic [7:0] TBC_RST_HIGH_DIV = 8'h00;
  localparam logic [7:0] TBC_RST_PB_DATA  = 8'h00;
  localparam logic [7:0] TBC_RST_PB_DIR   = 8'h01;
  localparam logic [7:0] TBC_RST_PB_CFG   = 8'h00;
  localparam logic [7:0] TBC_RST_PB_FSEL  = 8'h00;
  localparam int TBC_DIV_MSB   = 3;
  localparam int TBC_PIN0      = 0;
  localparam int TBC_CHAIN_W   = 15;
  localparam int TBC_TAP_LSB   = 7;
  localparam int TBC_IRQ_128   = 0;
  localparam int TBC_IRQ_32    = 2;
  localparam int TBC_IRQ_16    = 3;
  localparam int TBC_IRQ_2     = 6;
  localparam int TBC_SYNC_W    = 3;

  // ---------------------------------------------------------------
  // bus carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } tbc_bus_req_t;

  typedef struct packed {
    logic [3:0] req;
  } tbc_irq_t;

endpackage : tbc_pkg

/* hdl/tbc_fast_div.sv */
`timescale 1ns/1ps
module tbc_fast_div
  import tbc_pkg::*;
#(
  parameter int DIV_W = 4
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             arst_n,
  // control
  input  wire logic [DIV_W-1:0] div_field,
  // outputs
  output logic                  tick,
  output logic                  fast_divided_clock
);

  logic [DIV_W-1:0] cnt_reg;
  logic [DIV_W-1:0] last;

  // ---------------------------------------------------------------
  // 1/n counter, n = 16 - field
  // ---------------------------------------------------------------
  // terminal count is the inverted field: 0000 -> 15 -> 1/16
  assign last = ~div_field;
  assign tick = (cnt_reg >= last);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= '0;
    end else if (tick) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  // high in the first cycle of each period; for n=1 it stays high,
  // so consumers use tick as the enable of the divided clock
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      fast_divided_clock <= 1'b0;
    end else begin
      fast_divided_clock <= tick;
    end
  end

  property p_period;
    @(posedge clock) disable iff (!arst_n)
      (tick && $stable(div_field)) ##1 $stable(div_field)[*1]
        |-> cnt_reg == '0 || last == '0;
  endproperty
  a_period: assert property (p_period)
    else $error("divider did not restart after terminal count");

endmodule : tbc_fast_div

/* testbench/tb_tbc_time_base.sv */
`timescale 1ns/1ps
module tb_tbc_time_base;
  import tbc_pkg::*;

  // ---------------------------------------------------------------
  // design hookup
  // ---------------------------------------------------------------
  logic                   clock;
  logic                   arst_n;
  logic                   slow_system_clock;
  tbc_bus_req_t           bus_req;
  logic [7:0]             bus_rdata;
  logic [TBC_CHAIN_W-1:0] slow_taps;
  tbc_irq_t               irq;
  logic [5:0]             fast_div_taps;
  logic                   fast_divided_clock;
  logic                   fast_div_tick;
  logic                   port_b_pin0_o;
  logic                   port_b_pin0_oe_n;
  int                     errors;
  int                     checked;
  int                     irq_cnt [4];
  logic [7:0]             rd_val;
  logic [7:0]             rd_again;
  logic [15:0]            addr_tab [9];
  logic [7:0]             rst_tab  [9];
  int                     fields   [5];

  tbc_time_base tbc_time_base_i (
    .clock              (clock),
    .arst_n             (arst_n),
    .slow_system_clock  (slow_system_clock),
    .bus_req            (bus_req),
    .bus_rdata          (bus_rdata),
    .slow_taps          (slow_taps),
    .irq                (irq),
    .fast_div_taps      (fast_div_taps),
    .fast_divided_clock (fast_divided_clock),
    .fast_div_tick      (fast_div_tick),
    .port_b_pin0_o      (port_b_pin0_o),
    .port_b_pin0_oe_n   (port_b_pin0_oe_n)
  );

  always #4 clock = ~clock;

  // requests are one-cycle pulses, so count them on every edge
  always @(posedge clock or negedge arst_n) begin
    for (int i = 0; i < 4; i++) begin
      if (!arst_n) irq_cnt[i] <= 0;
      else if (irq.req[i] === 1'b1) irq_cnt[i] <= irq_cnt[i] + 1;
    end
  end

  // ---------------------------------------------------------------
  // bus and compare tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic reg_write(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    bus_req.addr  <= a;
    bus_req.wdata <= d;
    bus_req.wr    <= 1'b1;
    @(posedge clock);
    bus_req.wr    <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [15:0] a, output logic [7:0] d);
    @(posedge clock);
    bus_req.addr <= a;
    bus_req.rd   <= 1'b1;
    @(posedge clock);
    bus_req.rd   <= 1'b0;
    #1;
    d = bus_rdata;
  endtask : reg_read

  // eight bus clocks per slow period still give the three-flop filter
  // two agreeing samples of each level, and keep the long run short
  task automatic slow_falls(input int n);
    repeat (n) begin
      repeat (4) @(posedge clock);
      slow_system_clock <= 1'b0;
      repeat (4) @(posedge clock);
      slow_system_clock <= 1'b1;
    end
    repeat (10) @(posedge clock);
  endtask : slow_falls

  // a pulse train of period n shows exactly ten pulses in 10*n cycles
  task automatic measure(input int n);
    int hi;
    int tk;
    hi = 0;
    tk = 0;
    repeat (20) @(posedge clock);
    repeat (10 * n) begin
      @(posedge clock);
      #1;
      hi += int'(fast_divided_clock === 1'b1);
      tk += int'(fast_div_tick === 1'b1);
    end
    check(16'(hi), 16'd10);
    check(16'(tk), 16'd10);
  endtask : measure

  task automatic pin_watch(input logic toggling, input logic level);
    int changes;
    logic prev;
    changes = 0;
    repeat (3) @(posedge clock);
    #1;
    prev = port_b_pin0_o;
    repeat (8) begin
      @(posedge clock);
      #1;
      changes += int'(port_b_pin0_o !== prev);
      prev = port_b_pin0_o;
    end
    check(16'(changes), toggling ? 16'd8 : 16'd0);
    if (!toggling) check({15'h0000, port_b_pin0_o}, {15'h0000, level});
  endtask : pin_watch

  task automatic tally_and_finish();
    if (errors == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    int ed [6];
    logic [5:0] prev;
    clock             = 1'b0;
    arst_n            = 1'b0;
    slow_system_clock = 1'b1;
    bus_req           = '0;
    errors            = 0;
    checked           = 0;
    addr_tab = '{TBC_ADDR_LOW_TAP, TBC_ADDR_HIGH_DIV, TBC_ADDR_PB_DATA,
                 TBC_ADDR_PB_DIR, TBC_ADDR_PB_CFG_LO, TBC_ADDR_PB_CFG_HI,
                 TBC_ADDR_PB_FSEL_LO, TBC_ADDR_PB_FSEL_HI, 16'hf00c};
    rst_tab  = '{8'h00, 8'h00, TBC_RST_PB_DATA, TBC_RST_PB_DIR,
                 TBC_RST_PB_CFG, TBC_RST_PB_CFG, TBC_RST_PB_FSEL,
                 TBC_RST_PB_FSEL, 8'h00};
    fields   = '{0, 15, 8, 5, 14};
    repeat (10) @(posedge clock);
    arst_n <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      reg_read(addr_tab[i], rd_val);
      check({8'h00, rd_val}, {8'h00, rst_tab[i]});
    end
    check({1'b0, slow_taps}, 16'h0000);
    measure(16);
    // upper divider bits are not stored
    reg_write(TBC_ADDR_HIGH_DIV, 8'ha5);
    reg_read(TBC_ADDR_HIGH_DIV, rd_val);
    check({8'h00, rd_val}, 16'h0005);
    for (int i = 0; i < 5; i++) begin
      reg_write(TBC_ADDR_HIGH_DIV, 8'(fields[i]));
      measure(16 - fields[i]);
    end
    // fixed taps: bit k of period 2^k gives 64>>k rises in 64 cycles
    ed = '{0, 0, 0, 0, 0, 0};
    @(posedge clock);
    #1;
    prev = fast_div_taps;
    repeat (64) begin
      @(posedge clock);
      #1;
      ed[0] += int'(fast_div_taps[0] === 1'b1);
      for (int k = 1; k < 6; k++)
        ed[k] += int'(fast_div_taps[k] === 1'b1 && prev[k] === 1'b0);
      prev = fast_div_taps;
    end
    for (int k = 0; k < 6; k++) check(16'(ed[k]), 16'(64 >> k));
    // pin 0 as fast clock output, push-pull
    reg_write(TBC_ADDR_PB_FSEL_HI, 8'h01);
    reg_write(TBC_ADDR_PB_FSEL_LO, 8'h00);
    reg_write(TBC_ADDR_PB_CFG_HI, 8'h01);
    reg_write(TBC_ADDR_PB_CFG_LO, 8'h01);
    reg_write(TBC_ADDR_PB_DIR, 8'h00);
    reg_write(TBC_ADDR_PB_DATA, 8'h00);
    pin_watch(1'b1, 1'b0);
    check({15'h0000, port_b_pin0_oe_n}, 16'h0000);
    reg_write(TBC_ADDR_PB_DATA, 8'h01);
    pin_watch(1'b1, 1'b0);
    reg_write(TBC_ADDR_PB_FSEL_HI, 8'h00);
    pin_watch(1'b0, 1'b1);
    reg_write(TBC_ADDR_PB_FSEL_HI, 8'h01);
    reg_write(TBC_ADDR_PB_FSEL_LO, 8'h01);
    pin_watch(1'b0, 1'b1);
    reg_write(TBC_ADDR_PB_DIR, 8'h01);
    repeat (3) @(posedge clock);
    #1;
    check({15'h0000, port_b_pin0_oe_n}, 16'h0001);
    // 9856 falls set chain bits 7, 9, 10 and 13: all four request taps high
    slow_falls(9856);
    check({1'b0, slow_taps}, 16'h2680);
    check(16'(irq_cnt[0]), 16'd38);
    check(16'(irq_cnt[1]), 16'd9);
    check(16'(irq_cnt[2]), 16'd4);
    check(16'(irq_cnt[3]), 16'd0);
    reg_read(TBC_ADDR_LOW_TAP, rd_val);
    reg_read(TBC_ADDR_LOW_TAP, rd_again);
    check({8'h00, rd_val}, {8'h00, rd_again});
    check({8'h00, rd_val}, 16'h004d);
    // clearing knocks all four request taps from 1 to 0
    reg_write(TBC_ADDR_LOW_TAP, 8'hff);
    repeat (5) @(posedge clock);
    reg_read(TBC_ADDR_LOW_TAP, rd_val);
    check({8'h00, rd_val}, 16'h0000);
    check({1'b0, slow_taps}, 16'h0000);
    check(16'(irq_cnt[0]), 16'd39);
    check(16'(irq_cnt[1]), 16'd10);
    check(16'(irq_cnt[2]), 16'd5);
    check(16'(irq_cnt[3]), 16'd1);
    slow_falls(1);
    check({1'b0, slow_taps}, 16'h0001);
    tally_and_finish();
  end

  initial begin
    // the long slow-clock run takes about 80k cycles
    repeat (90000) @(posedge clock);
    errors++;
    tally_and_finish();
  end

endmodule : tb_tbc_time_base
